// >>> core/vic_pkg.sv
// constants, field positions and carrier types of the vectored interrupt control block
// assumes one 125 MHz clock, an axi4-lite master and a cpu core that flags instruction boundaries
package vic_pkg;
   // register byte offsets
   localparam logic [7:0] OFF_REQ  = 8'h00;
   localparam logic [7:0] OFF_MASK = 8'h04;
   localparam logic [7:0] OFF_PRIO = 8'h08;
   localparam logic [7:0] OFF_EDGE = 8'h0c;
   localparam logic [7:0] OFF_SCS  = 8'h10;
   localparam logic [7:0] OFF_PSW  = 8'h14;
   // reset values
   localparam logic [7:0] RST_REQ  = 8'h00;
   localparam logic [7:0] RST_MASK = 8'hff;
   localparam logic [7:0] RST_PRIO = 8'hff;
   localparam logic [7:0] RST_EDGE = 8'h00;
   localparam logic [7:0] RST_SCS  = 8'h00;
   localparam logic [7:0] RST_PSW  = 8'h02;
   // status word fields
   localparam int PSW_IE  = 7;
   localparam int PSW_ISP = 1;
   // source layout in the 16-bit flag words
   localparam int NUM_SRC = 12;
   localparam int SRC_WDT = 0;
   localparam int SRC_PIN = 1;
   localparam int WT_BIT  = 13;
   // vectors
   localparam logic [15:0] VEC_BASE = 16'h0004;
   localparam logic [15:0] VEC_NMI  = 16'h0004;
   localparam logic [15:0] VEC_BRK  = 16'h003e;
   // edge mode field codes, two bits per pin for pins 0 to 2
   localparam logic [1:0] EDGE_FALL = 2'b00;
   localparam logic [1:0] EDGE_RISE = 2'b01;
   localparam logic [1:0] EDGE_BOTH = 2'b11;
   // sample clock periods as divider masks
   localparam logic [7:0] SMP_MASK0 = 8'h03;
   localparam logic [7:0] SMP_MASK1 = 8'h0f;
   localparam logic [7:0] SMP_MASK2 = 8'h3f;
   localparam logic [7:0] SMP_MASK3 = 8'hff;
   // axi responses
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // cpu core events, one-cycle pulses except stack_psw
   typedef struct packed {
      logic       boundary;
      logic       software_break_op;
      logic       interrupt_return_op;
      logic       break_return_op;
      logic       pop_psw;
      logic       ei;
      logic       di;
      logic [7:0] stack_psw;
   } vic_cpu_t;

   // acknowledge presented to the cpu core
   typedef struct packed {
      logic        valid;
      logic        nmi;
      logic        software_break_op;
      logic [15:0] vector;
      logic [7:0]  pushed_psw;
   } vic_ack_t;
endpackage : vic_pkg

// >>> core/vic_top.sv
// vectored interrupt control: flags, pin edge logic, pin zero filter, status word
// assumes an axi4-lite master on aclk and pins that are asynchronous to aclk
//
// The register addresses and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/10ps
module vic_top (
   input  wire logic          aclk,
   input  wire logic          aresetn,
   input  wire logic [7:0]    s_axi_awaddr,
   input  wire logic          s_axi_awvalid,
   output logic               s_axi_awready,
   input  wire logic [31:0]   s_axi_wdata,
   input  wire logic [3:0]    s_axi_wstrb,
   input  wire logic          s_axi_wvalid,
   output logic               s_axi_wready,
   output logic [1:0]         s_axi_bresp,
   output logic               s_axi_bvalid,
   input  wire logic          s_axi_bready,
   input  wire logic [7:0]    s_axi_araddr,
   input  wire logic          s_axi_arvalid,
   output logic               s_axi_arready,
   output logic [31:0]        s_axi_rdata,
   output logic [1:0]         s_axi_rresp,
   output logic               s_axi_rvalid,
   input  wire logic          s_axi_rready,
   input  wire logic [11:0]   periph_req,
   input  wire logic          watch_test_req,
   input  wire logic          watchdog_request,
   input  wire logic          watchdog_mode1,
   input  wire logic [3:0]    ext_request_pins,
   input  wire vic_pkg::vic_cpu_t cpu_i,
   output vic_pkg::vic_ack_t  ack_o,
   output logic               standby_release
);
   // registers
   logic [15:0] request_flags_word;
   logic [15:0] mask_flags_word;
   logic [15:0] priority_flags_word;
   logic [7:0]  edge_mode;
   logic [7:0]  sample_clock_select;
   logic [7:0]  status_word;

   // bus state
   logic        aw_held;
   logic        w_held;
   logic [7:0]  aw_addr;
   logic [31:0] w_data;
   logic [3:0]  w_strb;
   logic        do_write;

   // pin path
   logic [3:0]  pin_meta;
   logic [3:0]  pin_sync;
   logic [3:0]  pin_prev;
   logic [7:0]  smp_cnt;
   logic        smp_en;
   logic        smp_last;
   logic        pin0_filt;
   logic [3:0]  pin_level;
   logic [3:0]  pin_hit;

   // interrupt state
   logic        nmi_pend;
   logic        nmi_busy;
   logic        skip;
   logic [15:0] hw_set;
   logic [15:0] ack_clr;
   logic [11:0] cand;
   logic [11:0] ok_hi;
   logic [11:0] ok_lo;
   logic        blocked;
   logic        take_brk;
   logic        take_nmi;
   logic        take_msk;
   logic [3:0]  win_idx;
   logic        win_prio;
   logic        restore;

   // lowest set index of a source vector
   function automatic logic [3:0] first_set(input logic [11:0] v);
      logic [3:0] r;
      r = 4'h0;
      for (int i = vic_pkg::NUM_SRC - 1; i >= 0; i--)
      begin
         if (v[i])
            r = 4'(i);
      end
      return r;
   endfunction : first_set

   // edge match for one pin
   function automatic logic edge_hit(input logic [1:0] md, input logic p, input logic c);
      logic r;
      r = 1'b0;
      unique case (md)
         vic_pkg::EDGE_RISE: r = ~p & c;
         vic_pkg::EDGE_BOTH: r = p ^ c;
         default:            r = p & ~c;
      endcase
      return r;
   endfunction : edge_hit

   // byte merge under write strobes
   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                           input logic [3:0] s);
      logic [15:0] r;
      r = old;
      if (s[0])
         r[7:0] = d[7:0];
      if (s[1])
         r[15:8] = d[15:8];
      return r;
   endfunction : merge16

   // mapped address check
   function automatic logic mapped(input logic [7:0] a);
      return a == vic_pkg::OFF_REQ || a == vic_pkg::OFF_MASK || a == vic_pkg::OFF_PRIO ||
             a == vic_pkg::OFF_EDGE || a == vic_pkg::OFF_SCS || a == vic_pkg::OFF_PSW;
   endfunction : mapped

   // write address and data taken in either order
   assign s_axi_awready = ~aw_held;
   assign s_axi_wready  = ~w_held;
   assign do_write      = aw_held & w_held & ~s_axi_bvalid;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held <= 1'b0;
         aw_addr <= 8'h00;
      end
      else if (s_axi_awvalid && !aw_held)
      begin
         aw_held <= 1'b1;
         aw_addr <= {s_axi_awaddr[7:2], 2'b00};
      end
      else if (do_write)
         aw_held <= 1'b0;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         w_held <= 1'b0;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
      end
      else if (s_axi_wvalid && !w_held)
      begin
         w_held <= 1'b1;
         w_data <= s_axi_wdata;
         w_strb <= s_axi_wstrb;
      end
      else if (do_write)
         w_held <= 1'b0;
   end

   // write response, error on unmapped offsets
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= vic_pkg::RESP_OKAY;
      end
      else if (do_write)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= mapped(aw_addr) ? vic_pkg::RESP_OKAY : vic_pkg::RESP_SLVERR;
      end
      else if (s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end

   // read channel, one read at a time
   assign s_axi_arready = ~s_axi_rvalid;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= vic_pkg::RESP_OKAY;
      end
      else if (s_axi_arvalid && !s_axi_rvalid)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= mapped({s_axi_araddr[7:2], 2'b00}) ? vic_pkg::RESP_OKAY
                                                            : vic_pkg::RESP_SLVERR;
         unique case ({s_axi_araddr[7:2], 2'b00})
            vic_pkg::OFF_REQ:  s_axi_rdata <= {16'h0000, request_flags_word};
            vic_pkg::OFF_MASK: s_axi_rdata <= {16'h0000, mask_flags_word};
            vic_pkg::OFF_PRIO: s_axi_rdata <= {16'h0000, priority_flags_word};
            vic_pkg::OFF_EDGE: s_axi_rdata <= {24'h000000, edge_mode};
            vic_pkg::OFF_SCS:  s_axi_rdata <= {24'h000000, sample_clock_select};
            vic_pkg::OFF_PSW:  s_axi_rdata <= {24'h000000, status_word};
            default:           s_axi_rdata <= 32'h0000_0000;
         endcase
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

   // pin synchroniser, two flip-flops
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pin_meta <= 4'hf;
         pin_sync <= 4'hf;
      end
      else
      begin
         pin_meta <= ext_request_pins;
         pin_sync <= pin_meta;
      end
   end

   // sample clock divider for pin zero
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         smp_cnt <= 8'h00;
      else
         smp_cnt <= smp_cnt + 8'h01;
   end

   always_comb
   begin
      unique case (sample_clock_select[1:0])
         2'd0:    smp_en = (smp_cnt & vic_pkg::SMP_MASK0) == 8'h00;
         2'd1:    smp_en = (smp_cnt & vic_pkg::SMP_MASK1) == 8'h00;
         2'd2:    smp_en = (smp_cnt & vic_pkg::SMP_MASK2) == 8'h00;
         default: smp_en = (smp_cnt & vic_pkg::SMP_MASK3) == 8'h00;
      endcase
   end

   // noise filter, level taken after two equal samples
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         smp_last  <= 1'b1;
         pin0_filt <= 1'b1;
      end
      else if (smp_en)
      begin
         smp_last <= pin_sync[0];
         if (smp_last == pin_sync[0])
            pin0_filt <= pin_sync[0];
      end
   end

   // edge detection on filtered pin zero and synced pins
   assign pin_level = {pin_sync[3:1], pin0_filt};

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         pin_prev <= 4'hf;
      else
         pin_prev <= pin_level;
   end

   always_comb
   begin
      for (int i = 0; i < 3; i++)
         pin_hit[i] = edge_hit(edge_mode[2*i +: 2], pin_prev[i], pin_level[i]);
      pin_hit[3] = pin_prev[3] & ~pin_level[3];
   end

   // hardware set sources, watchdog counts as maskable only outside mode 1
   always_comb
   begin
      hw_set = 16'h0000;
      hw_set[vic_pkg::NUM_SRC-1:5] = periph_req[vic_pkg::NUM_SRC-1:5];
      hw_set[vic_pkg::SRC_PIN +: 4] = pin_hit;
      hw_set[vic_pkg::SRC_WDT] = watchdog_request & ~watchdog_mode1;
      hw_set[vic_pkg::WT_BIT] = watch_test_req;
   end

   // candidate selection at instruction boundary
   assign cand    = request_flags_word[11:0] & ~mask_flags_word[11:0];
   assign ok_hi   = cand & ~priority_flags_word[11:0];
   assign ok_lo   = cand & priority_flags_word[11:0];
   assign blocked = skip | cpu_i.interrupt_return_op | cpu_i.break_return_op;
   assign take_brk = cpu_i.boundary & cpu_i.software_break_op;
   assign take_nmi = cpu_i.boundary & ~cpu_i.software_break_op & nmi_pend & ~nmi_busy & ~blocked;
   assign take_msk = cpu_i.boundary & ~cpu_i.software_break_op & ~(nmi_pend & ~nmi_busy) & ~blocked &
                     ~nmi_busy & status_word[vic_pkg::PSW_IE] &
                     ((|ok_hi) | ((|ok_lo) & status_word[vic_pkg::PSW_ISP]));
   assign win_idx  = (|ok_hi) ? first_set(ok_hi) : first_set(ok_lo);
   assign win_prio = priority_flags_word[win_idx];
   assign restore  = cpu_i.interrupt_return_op | cpu_i.break_return_op | cpu_i.pop_psw;

   always_comb
   begin
      ack_clr = 16'h0000;
      if (take_msk)
         ack_clr[win_idx] = 1'b1;
   end

   // request flags, a hardware set wins over any clear
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         request_flags_word <= {vic_pkg::RST_REQ, vic_pkg::RST_REQ};
      else if (do_write && aw_addr == vic_pkg::OFF_REQ)
         request_flags_word <= (merge16(request_flags_word, w_data, w_strb) & ~ack_clr) | hw_set;
      else
         request_flags_word <= (request_flags_word & ~ack_clr) | hw_set;
   end

   // mask and priority flags
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         mask_flags_word     <= {vic_pkg::RST_MASK, vic_pkg::RST_MASK};
         priority_flags_word <= {vic_pkg::RST_PRIO, vic_pkg::RST_PRIO};
      end
      else if (do_write && aw_addr == vic_pkg::OFF_MASK)
         mask_flags_word <= merge16(mask_flags_word, w_data, w_strb);
      else if (do_write && aw_addr == vic_pkg::OFF_PRIO)
         priority_flags_word <= merge16(priority_flags_word, w_data, w_strb);
   end

   // edge mode and sample clock select
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         edge_mode           <= vic_pkg::RST_EDGE;
         sample_clock_select <= vic_pkg::RST_SCS;
      end
      else if (do_write && w_strb[0] && aw_addr == vic_pkg::OFF_EDGE)
         edge_mode <= w_data[7:0];
      else if (do_write && w_strb[0] && aw_addr == vic_pkg::OFF_SCS)
         sample_clock_select <= w_data[7:0];
   end

   // status word: acknowledge, then restore, then enable ops, then bus write
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         status_word <= vic_pkg::RST_PSW;
      else if (take_brk || take_nmi || take_msk)
      begin
         status_word[vic_pkg::PSW_IE] <= 1'b0;
         if (take_nmi)
            status_word[vic_pkg::PSW_ISP] <= 1'b0;
         else if (take_msk)
            status_word[vic_pkg::PSW_ISP] <= win_prio;
      end
      else if (restore)
         status_word <= cpu_i.stack_psw;
      else if (cpu_i.ei)
         status_word[vic_pkg::PSW_IE] <= 1'b1;
      else if (cpu_i.di)
         status_word[vic_pkg::PSW_IE] <= 1'b0;
      else if (do_write && w_strb[0] && aw_addr == vic_pkg::OFF_PSW)
         status_word <= w_data[7:0];
   end

   // non-maskable pending, one bit so repeats collapse
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         nmi_pend <= 1'b0;
      else if (watchdog_request && watchdog_mode1)
         nmi_pend <= 1'b1;
      else if (take_nmi)
         nmi_pend <= 1'b0;
   end

   // non-maskable service window
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         nmi_busy <= 1'b0;
      else if (take_nmi)
         nmi_busy <= 1'b1;
      else if (cpu_i.interrupt_return_op)
         nmi_busy <= 1'b0;
   end

   // hold-off for one main routine instruction after a return
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         skip <= 1'b0;
      else if (cpu_i.interrupt_return_op || cpu_i.break_return_op)
         skip <= 1'b1;
      else if (cpu_i.boundary)
         skip <= 1'b0;
   end

   // acknowledge to the cpu core, one cycle
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         ack_o <= '0;
      else
      begin
         ack_o.valid      <= take_brk | take_nmi | take_msk;
         ack_o.nmi        <= take_nmi;
         ack_o.software_break_op        <= take_brk;
         ack_o.pushed_psw <= status_word;
         if (take_brk)
            ack_o.vector <= vic_pkg::VEC_BRK;
         else if (take_nmi)
            ack_o.vector <= vic_pkg::VEC_NMI;
         else
            ack_o.vector <= vic_pkg::VEC_BASE + {11'h000, win_idx, 1'b0};
      end
   end

   // standby release, watch-test flag only through its own mask
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         standby_release <= 1'b0;
      else
         standby_release <= (|cand) | nmi_pend |
            (request_flags_word[vic_pkg::WT_BIT] & ~mask_flags_word[vic_pkg::WT_BIT]);
   end
endmodule : vic_top

// >>> tb/vic_top_monitor.sv
// checker of the acknowledge and register bus ports
// assumes aclk and the synchronous active-low aresetn
`timescale 1ns/10ps
module vic_top_monitor (
   input wire logic              aclk,
   input wire logic              aresetn,
   input wire logic              s_axi_awvalid,
   input wire logic              s_axi_awready,
   input wire logic              s_axi_wvalid,
   input wire logic              s_axi_wready,
   input wire logic              s_axi_bvalid,
   input wire logic              s_axi_arvalid,
   input wire logic              s_axi_arready,
   input wire logic              s_axi_rvalid,
   input wire vic_pkg::vic_cpu_t cpu_i,
   input wire vic_pkg::vic_ack_t ack_o
);
   logic mack;
   logic wtake;
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // maskable acknowledge and write hand-off
   assign mack  = ack_o.valid && !ack_o.nmi && !ack_o.software_break_op;
   assign wtake = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   // acknowledge only after a boundary, with the documented vectors
   a_ack_after_boundary: assert property (ack_o.valid |-> $past(cpu_i.boundary))
      else $error("ack without boundary");
   a_break_wins: assert property (cpu_i.boundary && cpu_i.software_break_op |=> ack_o.valid && ack_o.software_break_op)
      else $error("break not taken");
   a_break_vector: assert property (ack_o.valid && ack_o.software_break_op |-> ack_o.vector == 16'h003e)
      else $error("break vector wrong");
   a_nmi_vector: assert property (ack_o.valid && ack_o.nmi |-> ack_o.vector == 16'h0004)
      else $error("nmi vector wrong");
   a_mask_vector: assert property (mack |-> ack_o.vector inside {[16'h0004:16'h001a]})
      else $error("maskable vector out of table");
   a_one_kind: assert property (ack_o.valid |-> !(ack_o.nmi && ack_o.software_break_op))
      else $error("two kinds at once");
   // register bus answers
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_write_answer: assert property (wtake |-> ##[1:2] s_axi_bvalid)
      else $error("write answer late");
   c_break: cover property (ack_o.valid && ack_o.software_break_op);
   c_nmi: cover property (ack_o.valid && ack_o.nmi);
   c_maskable: cover property (mack);
endmodule : vic_top_monitor

bind vic_top vic_top_monitor u_vic_top_monitor (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
   .cpu_i, .ack_o);

// >>> tb/vic_cpu_model.sv
// cpu core model: one instruction per go pulse, stack of status words
// assumes go and op change just after a rising edge
`timescale 1ns/10ps
module vic_cpu_model (
   input wire logic              aclk,
   input wire logic              aresetn,
   input wire logic              go,
   input wire logic [2:0]        op,
   input wire vic_pkg::vic_ack_t ack_o,
   output vic_pkg::vic_cpu_t     cpu_i
);
   logic [7:0] stk [8];
   logic [2:0] sp;
   // instruction kind: 1 break, 2 return, 3 break return, 4 pop, 5 enable
   always_comb
   begin
      cpu_i           = '0;
      cpu_i.boundary  = go;
      cpu_i.software_break_op       = go && op == 3'h1;
      cpu_i.interrupt_return_op      = go && op == 3'h2;
      cpu_i.break_return_op      = go && op == 3'h3;
      cpu_i.pop_psw   = go && op == 3'h4;
      cpu_i.ei        = go && op == 3'h5;
      cpu_i.stack_psw = stk[sp - 3'h1];
   end
   // push on acknowledge, pop on restoring ops
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         sp <= 3'h0;
      else if (ack_o.valid)
      begin
         stk[sp] <= ack_o.pushed_psw;
         sp      <= sp + 3'h1;
      end
      else if (cpu_i.interrupt_return_op || cpu_i.break_return_op || cpu_i.pop_psw)
         sp <= sp - 3'h1;
   end
endmodule : vic_cpu_model

// >>> tb/vic_top_tb_top.sv
// self-checking bench of the interrupt control top with a cpu core model
// assumes the hand-over timing of the top module
`timescale 1ns/10ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin fails++; $display("mismatch %s exp %h got %h", n, e, g); end end
module vic_top_tb_top;
   logic              aclk = 1'h0;
   logic              aresetn = 1'h0;
   logic [7:0]        s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0]       s_axi_wdata = 32'h0;
   logic [3:0]        s_axi_wstrb = 4'h0;
   logic              s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic              s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]        s_axi_bresp, s_axi_rresp, r;
   logic [31:0]       s_axi_rdata;
   logic [11:0]       periph_req = 12'h000;
   logic              watch_test_req = 1'h0, watchdog_request = 1'h0, watchdog_mode1 = 1'h0;
   logic [3:0]        ext_request_pins = 4'hf;
   logic              go = 1'h0, standby_release;
   logic [2:0]        op = 3'h0;
   logic [31:0]       d;
   vic_pkg::vic_cpu_t cpu_i;
   vic_pkg::vic_ack_t ack_o, ack;
   int                fails = 0, checked = 0;

   // 125 MHz clock
   always #4 aclk = ~aclk;

   vic_top u_vic_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .periph_req, .watch_test_req, .watchdog_request, .watchdog_mode1,
      .ext_request_pins, .cpu_i, .ack_o, .standby_release);
   vic_cpu_model u_vic_cpu_model (.aclk, .aresetn, .go, .op, .ack_o, .cpu_i);

   // axi4-lite write: each channel released once its ready is seen
   task automatic wr(input logic [7:0] a, input logic [15:0] v, input logic [3:0] s);
      logic ra, rw, rb;
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= {16'h0000, v};
      s_axi_wstrb   <= s;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid  <= 1'h1;
      s_axi_bready  <= 1'h1;
      do
      begin
         @(negedge aclk);
         ra = s_axi_awready;
         rw = s_axi_wready;
         rb = s_axi_bvalid;
         r  = s_axi_bresp;
         @(posedge aclk);
         if (ra)
            s_axi_awvalid <= 1'h0;
         if (rw)
            s_axi_wvalid <= 1'h0;
      end
      while (!rb);
      s_axi_bready <= 1'h0;
   endtask : wr

   // axi4-lite read into d and r
   task automatic rd(input logic [7:0] a);
      logic ra, rv;
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready  <= 1'h1;
      do
      begin
         @(negedge aclk);
         ra = s_axi_arready;
         rv = s_axi_rvalid;
         d  = s_axi_rdata;
         r  = s_axi_rresp;
         @(posedge aclk);
         if (ra)
            s_axi_arvalid <= 1'h0;
      end
      while (!rv);
      s_axi_rready <= 1'h0;
   endtask : rd

   // one instruction; ack holds what the cycle after it shows
   task automatic step(input logic [2:0] o);
      @(posedge aclk);
      go <= 1'h1;
      op <= o;
      @(posedge aclk);
      go <= 1'h0;
      @(negedge aclk);
      ack = ack_o;
   endtask : step

   // one-cycle source pulses, then settling time
   task automatic pls(input logic [11:0] p, input logic w, input logic t);
      @(posedge aclk);
      periph_req       <= p;
      watchdog_request <= w;
      watch_test_req   <= t;
      @(posedge aclk);
      periph_req       <= 12'h000;
      watchdog_request <= 1'h0;
      watch_test_req   <= 1'h0;
      repeat (2) @(negedge aclk);
   endtask : pls

   task automatic pin(input logic [3:0] v, input int n);
      @(posedge aclk);
      ext_request_pins <= v;
      repeat (n) @(posedge aclk);
   endtask : pin

   task automatic t_regs;
      logic [15:0] ex [6];
      ex = '{16'h0000, 16'hffff, 16'hffff, 16'h0000, 16'h0000, 16'h0002};
      for (int i = 0; i < 6; i++)
      begin
         rd(8'(4 * i));
         `CHK("reset", ex[i], d)
      end
      rd(8'h18);
      `CHK("unmapped", 2'h2, r)
      wr(8'h18, 16'hffff, 4'h3);
      `CHK("unmapped write", 2'h2, r)
      wr(8'h00, 16'h0fe0, 4'h3);
      `CHK("write okay", 2'h0, r)
      rd(8'h00);
      `CHK("req word", 16'h0fe0, d)
      wr(8'h00, 16'h0000, 4'h2);
      rd(8'h00);
      `CHK("req high", 16'h00e0, d)
      $display("test regs done");
   endtask : t_regs

   task automatic t_vector;
      wr(8'h00, 16'h0000, 4'h3);
      wr(8'h04, 16'hfd5f, 4'h3); // upper reserved bits kept set
      wr(8'h08, 16'hfdff, 4'h3);
      wr(8'h14, 16'h0082, 4'h1);
      pls(12'h2a0, 1'h0, 1'h0);
      `CHK("standby", 1'h1, standby_release)
      step(3'h0);
      `CHK("ack hi", {1'h1, 16'h0016, 8'h82}, {ack.valid, ack.vector, ack.pushed_psw})
      rd(8'h14);
      `CHK("psw", 16'h0000, d)
      rd(8'h00);
      `CHK("req", 16'h00a0, d)
      step(3'h5);
      step(3'h0);
      `CHK("low in service", 1'h0, ack.valid)
      step(3'h2);
      rd(8'h14);
      `CHK("psw return", 16'h0082, d)
      step(3'h0);
      `CHK("main instr", 1'h0, ack.valid)
      step(3'h0);
      `CHK("ack lo", {1'h1, 16'h000e}, {ack.valid, ack.vector})
      step(3'h2);
      $display("test vector done");
   endtask : t_vector

   task automatic t_standby;
      wr(8'h00, 16'h0000, 4'h3);
      wr(8'h04, 16'hdfff, 4'h3);
      pls(12'h000, 1'h0, 1'h1);
      `CHK("watch standby", 1'h1, standby_release)
      step(3'h0);
      `CHK("watch vector", 1'h0, ack.valid)
      wr(8'h00, 16'h0000, 4'h3);
      wr(8'h04, 16'hffff, 4'h3); // all sources masked before the peripheral pulse
      pls(12'h100, 1'h0, 1'h0);
      `CHK("masked standby", 1'h0, standby_release)
      step(3'h0);
      `CHK("masked vector", 1'h0, ack.valid)
      $display("test standby done");
   endtask : t_standby

   task automatic t_brk;
      wr(8'h00, 16'h0000, 4'h3);
      wr(8'h14, 16'h00c3, 4'h1);
      step(3'h1);
      `CHK("brk", {1'h1, 16'h003e, 8'hc3}, {ack.software_break_op, ack.vector, ack.pushed_psw})
      rd(8'h14);
      `CHK("brk psw", 16'h0043, d)
      step(3'h3);
      rd(8'h14);
      `CHK("brk return", 16'h00c3, d)
      wr(8'h14, 16'h0002, 4'h1);
      step(3'h1);
      `CHK("brk disabled", 2'h3, {ack.valid, ack.software_break_op})
      wr(8'h14, 16'h0040, 4'h1);
      step(3'h4);
      rd(8'h14);
      `CHK("pop", 16'h0002, d)
      $display("test brk done");
   endtask : t_brk

   task automatic t_nmi;
      wr(8'h00, 16'h0000, 4'h3); // watchdog flag held clear in mode 1
      wr(8'h08, 16'hffff, 4'h3); // watchdog priority set in mode 1
      watchdog_mode1 <= 1'h1;
      pls(12'h000, 1'h1, 1'h0);
      step(3'h0);
      `CHK("nmi", {2'h3, 16'h0004}, {ack.valid, ack.nmi, ack.vector})
      rd(8'h14);
      `CHK("nmi psw", 16'h0000, d)
      pls(12'h000, 1'h1, 1'h0);
      pls(12'h000, 1'h1, 1'h0);
      step(3'h0);
      `CHK("nmi nested", 1'h0, ack.valid)
      step(3'h2);
      step(3'h0);
      `CHK("nmi main instr", 1'h0, ack.valid)
      step(3'h0);
      `CHK("nmi again", 2'h3, {ack.valid, ack.nmi})
      step(3'h2);
      step(3'h0);
      step(3'h0);
      `CHK("nmi collapsed", 1'h0, ack.valid)
      watchdog_mode1 <= 1'h0;
      // outside mode 1 the watchdog only sets its maskable flag
      pls(12'h000, 1'h1, 1'h0);
      rd(8'h00);
      `CHK("watchdog maskable", 16'h0001, d)
      $display("test nmi done");
   endtask : t_nmi

   task automatic t_pins;
      wr(8'h00, 16'h0000, 4'h3);
      wr(8'h0c, 16'h0034, 4'h1);
      pin(4'h1, 8);
      rd(8'h00);
      `CHK("falls", 16'h0018, d)
      wr(8'h00, 16'h0000, 4'h3);
      pin(4'hf, 8);
      rd(8'h00);
      `CHK("rises", 16'h000c, d)
      pin(4'he, 2);
      pin(4'hf, 12);
      rd(8'h00);
      `CHK("short pulse", 16'h000c, d)
      pin(4'he, 20);
      pin(4'hf, 4);
      rd(8'h00);
      `CHK("filtered", 16'h000e, d)
      // slower sample clock: a 12-cycle pulse meets one sample at most
      wr(8'h10, 16'h0001, 4'h1);
      wr(8'h00, 16'h0000, 4'h3);
      pin(4'he, 12);
      pin(4'hf, 40);
      rd(8'h00);
      `CHK("slow sample", 16'h0000, d)
      $display("test pins done");
   endtask : t_pins

   // verdict and end of run
   task automatic summarize;
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : summarize

   // main sequence after a three-cycle reset
   initial
   begin
      repeat (3) @(posedge aclk);
      aresetn <= 1'h1;
      t_regs;
      t_vector;
      t_standby;
      t_brk;
      t_nmi;
      t_pins;
      summarize;
   end

   // hang guard at 25000 cycles, far beyond the few hundred cycles the tests take
   initial
   begin
      #200000;
      fails++;
      summarize;
   end
endmodule : vic_top_tb_top
